// file: common/isrp_pkg.sv
// Shared constants, state codes and carriers for the I2C register port
package isrp_pkg;

   // ==========================================================
   // Widths and counts
   localparam int ADDR_W = 16;
   localparam int BYTE_W = 8;
   localparam int DEV_W = 7;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
   localparam logic [CNT_W-1:0] BIT_DONE = 4'h8;
   localparam int MSB = BYTE_W - 1;

   // ==========================================================
   // Byte position inside a write transfer
   localparam logic [1:0] IDX_ADDR_HI = 2'h0;
   localparam logic [1:0] IDX_ADDR_LO = 2'h1;
   localparam logic [1:0] IDX_DATA = 2'h2;

   // ==========================================================
   // Register port constants
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
   localparam logic [ADDR_W-1:0] UPDATE_REG = 16'h000F;
   localparam int UPDATE_BIT = 0;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic SDA_LOW = 1'b0;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_NACK = 1'b1;
   localparam logic RW_READ = 1'b1;
   // Arbitrary slave address defaults, picked by the select pin
   localparam logic [DEV_W-1:0] DEV_ADDR0_DEF = 7'h2A;
   localparam logic [DEV_W-1:0] DEV_ADDR1_DEF = 7'h2B;

   // ==========================================================
   // Timing: fastest SCL against the logic clock
   localparam int CLK_KHZ = 10000;
   localparam int SCL_STD_KHZ = 100;
   localparam int SCL_FAST_KHZ = 400;
   localparam int SCL_FAST_CYC = CLK_KHZ / SCL_FAST_KHZ;

   // ==========================================================
   // Port state machine, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_WACK = 8'h04,
      ST_ACK = 8'h08,
      ST_RX = 8'h10,
      ST_TX = 8'h20,
      ST_MACK = 8'h40,
      ST_TXL = 8'h80
   } isrp_state_t;

   // ==========================================================
   // Carriers toward the register file
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } isrp_wr_t;

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } isrp_rd_t;

endpackage

// file: hw/isrp_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module isrp_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic async_in,
   output logic sync_out
);

   logic meta_r;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule
`default_nettype wire

// file: hw/isrp_slave_port.sv
// I2C slave port giving a bus master 16-bit addressed register access
`timescale 1ns/100ps
`default_nettype none

module isrp_slave_port
   import isrp_pkg::*;
#(
   parameter logic [DEV_W-1:0] DEV_ADDR0 = DEV_ADDR0_DEF,
   parameter logic [DEV_W-1:0] DEV_ADDR1 = DEV_ADDR1_DEF
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic scl_clk_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic dev_sel_in,
   output isrp_wr_t wr_out,
   output isrp_rd_t rd_req_out,
   input wire logic [BYTE_W-1:0] rd_data_in,
   output logic io_update_out,
   output logic busy_out
);

   logic link_tog_r;
   logic link_bit_r;
   logic scl_s;
   logic sda_s;
   logic tog_s;
   logic sel_s;
   logic scl_d_r;
   logic sda_d_r;
   logic tog_d_r;
   logic rise_ev;
   logic fall_ev;
   logic start_ev;
   logic stop_ev;
   logic rx_bit;
   logic [BYTE_W-1:0] rx_byte;
   logic [DEV_W-1:0] own_addr;
   isrp_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [BYTE_W-1:0] sh_r;
   logic [BYTE_W-1:0] tx_r;
   logic oe_r;
   logic rw_r;
   logic [1:0] idx_r;
   logic [ADDR_W-1:0] addr_r;
   isrp_wr_t wr_r;
   isrp_rd_t rd_r;
   logic upd_r;
   logic rd_cap_r;
   logic [BYTE_W-1:0] rd_buf_r;

   // ==========================================================
   // Link domain: one capture per SCL rising edge
   // SDA is stable while SCL is high, so the rising edge is a safe sample point
   always_ff @(posedge scl_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         link_tog_r <= 1'b0;
         link_bit_r <= LINE_IDLE;
      end else begin
         link_tog_r <= ~link_tog_r;
         link_bit_r <= sda_in;
      end
   end

   // ==========================================================
   // Crossings into the logic clock
   // Lines reset high so the release of reset never looks like a start
   isrp_sync #(.RST_VAL(LINE_IDLE)) u_scl_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(scl_clk_in),
      .sync_out(scl_s)
   );

   isrp_sync #(.RST_VAL(LINE_IDLE)) u_sda_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   isrp_sync #(.RST_VAL(1'b0)) u_tog_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(link_tog_r),
      .sync_out(tog_s)
   );

   isrp_sync #(.RST_VAL(1'b0)) u_sel_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .async_in(dev_sel_in),
      .sync_out(sel_s)
   );

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_d_r <= LINE_IDLE;
         sda_d_r <= LINE_IDLE;
         tog_d_r <= 1'b0;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         tog_d_r <= tog_s;
      end
   end

   // ==========================================================
   // Bus events
   // The captured bit is read only once its toggle has crossed, so it is stable
   assign rise_ev = tog_s ^ tog_d_r;
   assign fall_ev = scl_d_r & ~scl_s;
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign rx_bit = link_bit_r;
   assign rx_byte = {sh_r[MSB-1:0], rx_bit};
   assign own_addr = sel_s ? DEV_ADDR1 : DEV_ADDR0;

   // ==========================================================
   // Port state machine
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ST_IDLE;
         cnt_r <= CNT_ZERO;
         sh_r <= BYTE_ZERO;
         tx_r <= BYTE_ZERO;
         oe_r <= 1'b0;
         rw_r <= 1'b0;
         idx_r <= IDX_ADDR_HI;
         addr_r <= ADDR_RESET;
         wr_r <= '0;
         rd_r <= '0;
         upd_r <= 1'b0;
      end else begin
         wr_r.valid <= 1'b0;
         rd_r.valid <= 1'b0;
         upd_r <= 1'b0;
         if (start_ev) begin
            // Repeated start too; a half-received byte is simply dropped
            state_r <= ST_ADDR;
            cnt_r <= CNT_ZERO;
            oe_r <= 1'b0;
         end else if (stop_ev) begin
            state_r <= ST_IDLE;
            cnt_r <= CNT_ZERO;
            oe_r <= 1'b0;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  oe_r <= 1'b0;
               end
               ST_ADDR: begin
                  if (rise_ev) begin
                     sh_r <= rx_byte;
                     cnt_r <= cnt_r + CNT_ONE;
                     if (cnt_r == BIT_LAST) begin
                        if (sh_r[DEV_W-1:0] == own_addr) begin
                           rw_r <= rx_bit;
                           idx_r <= IDX_ADDR_HI;
                           state_r <= ST_WACK;
                        end else begin
                           state_r <= ST_IDLE;
                        end
                     end
                  end
               end
               ST_WACK: begin
                  if (fall_ev) begin
                     oe_r <= 1'b1;
                     cnt_r <= CNT_ZERO;
                     state_r <= ST_ACK;
                     if (rw_r == RW_READ) begin
                        rd_r.valid <= 1'b1;
                        rd_r.addr <= addr_r;
                     end
                  end
               end
               ST_ACK: begin
                  if (fall_ev) begin
                     cnt_r <= CNT_ZERO;
                     if (rw_r == RW_READ) begin
                        oe_r <= ~rd_buf_r[MSB];
                        tx_r <= {rd_buf_r[MSB-1:0], LINE_IDLE};
                        state_r <= ST_TX;
                     end else begin
                        oe_r <= 1'b0;
                        state_r <= ST_RX;
                     end
                  end
               end
               ST_RX: begin
                  if (rise_ev) begin
                     sh_r <= rx_byte;
                     if (cnt_r == BIT_LAST) begin
                        cnt_r <= CNT_ZERO;
                        state_r <= ST_WACK;
                        unique case (idx_r)
                           IDX_ADDR_HI: begin
                              addr_r[ADDR_W-1:BYTE_W] <= rx_byte;
                              idx_r <= IDX_ADDR_LO;
                           end
                           IDX_ADDR_LO: begin
                              addr_r[BYTE_W-1:0] <= rx_byte;
                              idx_r <= IDX_DATA;
                           end
                           default: begin
                              // Data phase holds for any byte count
                              wr_r.valid <= 1'b1;
                              wr_r.addr <= addr_r;
                              wr_r.data <= rx_byte;
                              addr_r <= addr_r + ADDR_STEP;
                              if (addr_r == UPDATE_REG && rx_byte[UPDATE_BIT]) begin
                                 upd_r <= 1'b1;
                              end
                           end
                        endcase
                     end else begin
                        cnt_r <= cnt_r + CNT_ONE;
                     end
                  end
               end
               ST_TX: begin
                  if (rise_ev) begin
                     cnt_r <= cnt_r + CNT_ONE;
                  end else if (fall_ev) begin
                     if (cnt_r == BIT_DONE) begin
                        oe_r <= 1'b0;
                        state_r <= ST_MACK;
                     end else begin
                        oe_r <= ~tx_r[MSB];
                        tx_r <= {tx_r[MSB-1:0], LINE_IDLE};
                     end
                  end
               end
               ST_MACK: begin
                  if (rise_ev) begin
                     if (rx_bit == LINE_NACK) begin
                        state_r <= ST_IDLE;
                     end else begin
                        addr_r <= addr_r + ADDR_STEP;
                        rd_r.valid <= 1'b1;
                        rd_r.addr <= addr_r + ADDR_STEP;
                        state_r <= ST_TXL;
                     end
                  end
               end
               ST_TXL: begin
                  if (fall_ev) begin
                     cnt_r <= CNT_ZERO;
                     oe_r <= ~rd_buf_r[MSB];
                     tx_r <= {rd_buf_r[MSB-1:0], LINE_IDLE};
                     state_r <= ST_TX;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Read data capture, one cycle after the request
   // The update bit self-clears, so it always reads back as zero
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_cap_r <= 1'b0;
         rd_buf_r <= BYTE_ZERO;
      end else begin
         rd_cap_r <= rd_r.valid;
         if (rd_cap_r) begin
            rd_buf_r <= rd_data_in;
            if (rd_r.addr == UPDATE_REG) begin
               rd_buf_r[UPDATE_BIT] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Outputs; SDA is open drain and SCL has no driver at all
   assign sda_out = SDA_LOW;
   assign sda_oe_out = oe_r;
   assign wr_out = wr_r;
   assign rd_req_out = rd_r;
   assign io_update_out = upd_r;
   assign busy_out = (state_r != ST_IDLE);

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);

   sequence start_s;
      start_ev;
   endsequence

   sequence nack_s;
      state_r == ST_MACK && rise_ev && rx_bit == LINE_NACK;
   endsequence

   sequence miss_s;
      state_r == ST_ADDR && rise_ev && cnt_r == BIT_LAST && sh_r[DEV_W-1:0] != own_addr;
   endsequence

   sequence rd_ask_s;
      rd_r.valid ##1 rd_cap_r && !rd_r.valid;
   endsequence

   start_addr_a: assert property (start_s |=> state_r == ST_ADDR && cnt_r == CNT_ZERO && !oe_r)
      else $error("start did not restart address reception");
   stop_idle_a: assert property (stop_ev |=> state_r == ST_IDLE && !oe_r)
      else $error("stop did not return port to idle");
   sda_change_a: assert property (
      $changed(oe_r) && !$past(start_ev || stop_ev) |-> !scl_d_r)
      else $error("SDA drive changed while SCL high");
   nack_idle_a: assert property (nack_s |=> state_r == ST_IDLE ##1 !oe_r)
      else $error("no-acknowledge did not end the read");
   addr_miss_a: assert property (miss_s |=> state_r == ST_IDLE [*2])
      else $error("foreign address was not ignored");
   ack_drive_a: assert property (state_r == ST_ACK |-> oe_r)
      else $error("acknowledge slot not driven low");
   wr_place_a: assert property (
      wr_r.valid |-> $past(state_r == ST_RX && idx_r == IDX_DATA && cnt_r == BIT_LAST))
      else $error("register write outside data phase");
   addr_step_a: assert property (wr_r.valid |-> addr_r == wr_r.addr + ADDR_STEP)
      else $error("register address did not advance");
   upd_pulse_a: assert property (
      upd_r |-> wr_r.valid && wr_r.addr == UPDATE_REG && wr_r.data[UPDATE_BIT])
      else $error("update pulse without its register write");
   rd_fetch_a: assert property (rd_r.valid |-> rd_ask_s)
      else $error("read request not captured next cycle");
   read_start_a: assert property (
      rd_r.valid && $past(state_r == ST_WACK) |-> rd_r.addr == addr_r)
      else $error("read did not start at current address");

endmodule
`default_nettype wire

// file: verification/isrp_master_model.sv
// Behavioural I2C bus master driving SCL and pulling SDA for the bench
`timescale 1ns/100ps
`default_nettype none

module isrp_master_model (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_in
);
   // ==========================================================
   // Link tick of 64 ns; SCL only moves inside frames
   logic tick;
   int h_ticks;

   initial begin
      tick = 1'b0;
      scl_out = 1'b1;
      sda_low_out = 1'b0;
      h_ticks = 20; // Near 400 kHz
      forever #32 tick = ~tick;
   end

   task automatic wait_t(input int n);
      repeat (n) @(posedge tick);
   endtask

   // ==========================================================
   // Line conditions; start also serves as repeated start
   task automatic start();
      sda_low_out = 1'b0;
      wait_t(h_ticks / 2);
      scl_out = 1'b1;
      wait_t(h_ticks);
      sda_low_out = 1'b1;
      wait_t(h_ticks);
      scl_out = 1'b0;
      wait_t(h_ticks / 2);
   endtask

   task automatic stop();
      sda_low_out = 1'b1;
      wait_t(h_ticks / 2);
      scl_out = 1'b1;
      wait_t(h_ticks);
      sda_low_out = 1'b0;
      wait_t(h_ticks);
   endtask

   // ==========================================================
   // Bits: data only moves while SCL is low
   task automatic bit_out(input logic b);
      sda_low_out = ~b;
      wait_t(h_ticks / 2);
      scl_out = 1'b1;
      wait_t(h_ticks);
      scl_out = 1'b0;
      wait_t(h_ticks / 2);
   endtask

   task automatic bit_in(output logic b);
      sda_low_out = 1'b0;
      wait_t(h_ticks / 2);
      scl_out = 1'b1;
      wait_t(h_ticks / 2);
      b = sda_in;
      wait_t(h_ticks / 2);
      scl_out = 1'b0;
      wait_t(h_ticks / 2);
   endtask

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   endtask

   task automatic read_byte(input logic ack, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_in(b);
         d[i] = b;
      end
      bit_out(~ack); // Last byte left high
   endtask
endmodule
`default_nettype wire

// file: verification/isrp_slave_port_bench.sv
// Self-checking bench for the I2C register port
`timescale 1ns/100ps
`default_nettype none

module isrp_slave_port_bench
   import isrp_pkg::*;
;
   logic clk_in;
   logic rst_b_in;
   logic dev_sel_in;
   logic [BYTE_W-1:0] rd_data_in = 8'h00;
   wire logic scl_line;
   wire logic sda_low;
   wire logic sda_line;
   logic sda_out;
   logic sda_oe_out;
   isrp_wr_t wr_out;
   isrp_rd_t rd_req_out;
   logic io_update_out;
   logic busy_out;
   int n_errors;
   int check_count;
   int n_update;
   logic [23:0] wq[$];

   // Open drain with pull-up: any party pulling wins
   assign sda_line = ~sda_low & (~sda_oe_out | sda_out);

   isrp_master_model i_master (.scl_out(scl_line), .sda_low_out(sda_low), .sda_in(sda_line));

   isrp_slave_port i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_clk_in(scl_line),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .dev_sel_in(dev_sel_in),
      .wr_out(wr_out), .rd_req_out(rd_req_out), .rd_data_in(rd_data_in),
      .io_update_out(io_update_out), .busy_out(busy_out));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // ==========================================================
   // Register file stand-in: data the cycle after a request
   function automatic logic [7:0] rd_val(input logic [15:0] a);
      return a[15:8] ^ a[7:0] ^ 8'h5A;
   endfunction

   always @(posedge clk_in) begin
      if (rd_req_out.valid === 1'b1) rd_data_in <= #1 rd_val(rd_req_out.addr);
      if (wr_out.valid === 1'b1) wq.push_back({wr_out.addr, wr_out.data});
      if (io_update_out === 1'b1) n_update++;
   end

   // ==========================================================
   // Checking and closing
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("Checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 40 && busy_out !== 1'b0; i++) @(posedge clk_in);
      if (busy_out !== 1'b0) begin
         check("busy_out idle wait", 24'(busy_out), 24'h0);
         results();
      end
   endtask

   task automatic wbyte(input logic [7:0] d, input logic exp_ack);
      logic a;
      i_master.write_byte(d, a);
      check("acknowledge", 24'(a), 24'(exp_ack));
   endtask

   task automatic rbyte(input logic ack, input logic [7:0] exp);
      logic [7:0] d;
      i_master.read_byte(ack, d);
      check("read byte", 24'(d), 24'(exp));
   endtask

   task automatic pop_wr(input logic [23:0] exp);
      logic [23:0] v;
      v = 'x;
      if (wq.size() > 0) v = wq.pop_front();
      check("register write", v, exp);
   endtask

   task automatic set_addr(input logic [6:0] dev, input logic [15:0] a);
      i_master.start();
      wbyte({dev, 1'b0}, 1'b1);
      wbyte(a[15:8], 1'b1);
      wbyte(a[7:0], 1'b1);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_write();
      set_addr(DEV_ADDR0_DEF, 16'h1234);
      for (int i = 0; i < 3; i++) wbyte(8'hC0 + 8'(i), 1'b1);
      i_master.stop();
      wait_idle();
      for (int i = 0; i < 3; i++) pop_wr({16'h1234 + 16'(i), 8'hC0 + 8'(i)});
      check("write count", 24'(wq.size()), 24'h0);
      $display("Test write done");
   endtask

   task automatic t_foreign();
      i_master.start();
      wbyte({DEV_ADDR1_DEF, 1'b0}, 1'b0);
      check("busy after nack", 24'(busy_out), 24'h0);
      wbyte(8'h00, 1'b0);
      i_master.stop();
      wait_idle();
      check("foreign writes", 24'(wq.size()), 24'h0);
      @(posedge clk_in);
      #1 dev_sel_in = 1'b1;
      repeat (4) @(posedge clk_in);
      set_addr(DEV_ADDR1_DEF, 16'h0040);
      wbyte(8'h11, 1'b1);
      i_master.stop();
      wait_idle();
      pop_wr({16'h0040, 8'h11});
      @(posedge clk_in);
      #1 dev_sel_in = 1'b0;
      repeat (4) @(posedge clk_in);
      $display("Test address select done");
   endtask

   task automatic t_read();
      set_addr(DEV_ADDR0_DEF, 16'h0100);
      i_master.stop();
      wait_idle();
      check("send byte writes", 24'(wq.size()), 24'h0);
      i_master.start();
      wbyte({DEV_ADDR0_DEF, RW_READ}, 1'b1);
      rbyte(1'b1, rd_val(16'h0100));
      rbyte(1'b1, rd_val(16'h0101));
      rbyte(1'b0, rd_val(16'h0102));
      repeat (5) @(posedge clk_in);
      check("busy after master nack", 24'(busy_out), 24'h0);
      check("sda released", 24'(sda_oe_out), 24'h0);
      i_master.stop();
      wait_idle();
      $display("Test read done");
   endtask

   task automatic t_combined();
      i_master.h_ticks = 78; // Near 100 kHz
      set_addr(DEV_ADDR0_DEF, 16'h0200);
      i_master.start();
      wbyte({DEV_ADDR0_DEF, RW_READ}, 1'b1);
      rbyte(1'b1, rd_val(16'h0200));
      rbyte(1'b0, rd_val(16'h0201));
      i_master.stop();
      wait_idle();
      i_master.h_ticks = 20;
      check("combined writes", 24'(wq.size()), 24'h0);
      $display("Test combined read done");
   endtask

   task automatic t_partial();
      set_addr(DEV_ADDR0_DEF, 16'h0020);
      for (int i = 0; i < 4; i++) i_master.bit_out(i < 2);
      set_addr(DEV_ADDR0_DEF, 16'h0030);
      wbyte(8'h99, 1'b1);
      set_addr(DEV_ADDR0_DEF, 16'h0050);
      i_master.bit_out(1'b1);
      i_master.bit_out(1'b0);
      i_master.stop();
      wait_idle();
      pop_wr({16'h0030, 8'h99});
      check("partial writes", 24'(wq.size()), 24'h0);
      $display("Test partial byte done");
   endtask

   task automatic t_update();
      int base;
      base = n_update;
      set_addr(DEV_ADDR0_DEF, UPDATE_REG);
      wbyte(8'h01, 1'b1);
      i_master.stop();
      wait_idle();
      check("update pulses", 24'(n_update - base), 24'h1);
      set_addr(DEV_ADDR0_DEF, UPDATE_REG);
      wbyte(8'h02, 1'b1);
      i_master.stop();
      wait_idle();
      check("update pulses", 24'(n_update - base), 24'h1);
      // Update bit clears itself, so it never reads back as set
      set_addr(DEV_ADDR0_DEF, UPDATE_REG);
      i_master.start();
      wbyte({DEV_ADDR0_DEF, RW_READ}, 1'b1);
      rbyte(1'b0, rd_val(UPDATE_REG) & 8'hFE);
      i_master.stop();
      wait_idle();
      check("update pulses after read", 24'(n_update - base), 24'h1);
      pop_wr({UPDATE_REG, 8'h01});
      pop_wr({UPDATE_REG, 8'h02});
      $display("Test update done");
   endtask

   initial begin
      n_errors = 0;
      check_count = 0;
      rst_b_in = 1'b0;
      dev_sel_in = 1'b0;
      repeat (5) @(posedge clk_in);
      #1 rst_b_in = 1'b1;
      repeat (4) @(posedge clk_in);
      check("sda drive after reset", 24'(sda_oe_out), 24'h0);
      check("busy after reset", 24'(busy_out), 24'h0);
      t_write();
      t_foreign();
      t_read();
      t_combined();
      t_partial();
      t_update();
      results();
   end
endmodule
`default_nettype wire
